// ---- dfl_pkg.sv ----
// ==========================================================================
// Flag bank constants
package dfl_pkg;

  // ========================================================================
  // Flag positions in the latched flag vector
  localparam int unsigned NUM_FLAGS         = 22;
  localparam int unsigned F_CANL_TO_BAT     = 0;
  localparam int unsigned F_CANL_TO_REG     = 1;
  localparam int unsigned F_CANL_TO_GND     = 2;
  localparam int unsigned F_CANH_TO_BAT     = 3;
  localparam int unsigned F_CANH_TO_REG     = 4;
  localparam int unsigned F_CANH_TO_GND     = 5;
  localparam int unsigned F_SW_THREE_SHORT  = 6;
  localparam int unsigned F_SW_TWO_SHORT    = 7;
  localparam int unsigned F_SPI_PARITY      = 8;
  localparam int unsigned F_CS_LONG         = 9;
  localparam int unsigned F_SUP2_UV         = 10;
  localparam int unsigned F_SUP1_OV         = 11;
  localparam int unsigned F_IO0_THERMAL     = 12;
  localparam int unsigned F_WD_HALF         = 13;
  localparam int unsigned F_WAKE_IO13       = 14;
  localparam int unsigned F_WAKE_IO02       = 15;
  localparam int unsigned F_WAKE_SPI        = 16;
  localparam int unsigned F_WAKE_FORCED     = 17;
  localparam int unsigned F_INT_TIMEOUT     = 18;
  localparam int unsigned F_LP_REG_OFF      = 19;
  localparam int unsigned F_RST_REQUEST     = 20;
  localparam int unsigned F_DEBUG_EXIT      = 21;

  // ========================================================================
  // Reset values
  localparam logic [NUM_FLAGS-1:0] FLAGS_RST = 22'h000000;

  // ========================================================================
  // Timing
  localparam int unsigned CLK_PERIOD_NS     = 10;
  localparam int unsigned CS_LOW_MAX_NS     = 2000000;  // 2.0 ms
  localparam int unsigned CS_LOW_CYCLES     = CS_LOW_MAX_NS / CLK_PERIOD_NS;
  localparam int unsigned CS_CNT_W          = 18;
  localparam int unsigned WD_W              = 16;

endpackage

// ---- dfl_flag_bank.sv ----
// Contract
// R1: six latched bus wire short flags
// R2: fault flag clears when recovered and read
// R3: latch high side three/two short flags
// R4: parity error flag, cleared by read
// R5: chip select low over 2.0 ms flag
// R6: supply two UV, supply one OV flags
// R7: line zero switch thermal flag, recovered-and-read
// R8: flash mode watchdog past half period flag
// R9: two I/O wake source flags, read clears
// R10: SPI wake from low power flag
// R11: forced wake source flag, read clears
// R12: interrupt service timeout flag, read clears
// R13: low power regulator off selected flag
// R14: SPI reset request cause flag
// R15: hardware debug exit flag, read clears
// R16: set coinciding with read wins
`timescale 1ns/1ps

module dfl_flag_bank #(
  parameter int unsigned CS_LOW_CYCLES  = dfl_pkg::CS_LOW_CYCLES,
  parameter int unsigned WD_W           = dfl_pkg::WD_W
) (
  input  wire logic                         mclk,
  input  wire logic                         rstn,
  input  wire logic                         canl_short_bat,
  input  wire logic                         canl_short_reg,
  input  wire logic                         canl_short_gnd,
  input  wire logic                         canh_short_bat,
  input  wire logic                         canh_short_reg,
  input  wire logic                         canh_short_gnd,
  input  wire logic                         high_side_three_short,
  input  wire logic                         high_side_two_short,
  input  wire logic                         spi_parity_fail,
  input  wire logic                         chip_select_bar,
  input  wire logic                         supply_two_under,
  input  wire logic                         supply_one_over,
  input  wire logic                         io0_switch_hot,
  input  wire logic                         flash_mode,
  input  wire logic [WD_W-1:0]              wd_elapsed,
  input  wire logic [WD_W-1:0]              wd_period,
  input  wire logic                         wake_io13,
  input  wire logic                         wake_io02,
  input  wire logic                         spi_wake_cmd,
  input  wire logic                         lp_reg_on_mode,
  input  wire logic                         forced_wake,
  input  wire logic                         int_service_expired,
  input  wire logic                         lp_reg_off_select,
  input  wire logic                         spi_reset_done,
  input  wire logic                         debug_mode,
  input  wire logic                         debug_entry_pin_low,
  input  wire logic [dfl_pkg::NUM_FLAGS-1:0] flag_read,
  output logic      [dfl_pkg::NUM_FLAGS-1:0] flags
);

  // ========================================================================
  // State
  typedef struct packed {
    logic [dfl_pkg::NUM_FLAGS-1:0] flags;
    logic [dfl_pkg::CS_CNT_W-1:0]  cs_cnt;
    logic                          wd_over;
  } dfl_state_t;

  // Limit is cut to the counter width; keep the parameter below 2**CS_CNT_W
  localparam logic [dfl_pkg::CS_CNT_W-1:0] CS_LIMIT =
    (dfl_pkg::CS_CNT_W)'(CS_LOW_CYCLES);
  localparam logic [dfl_pkg::CS_CNT_W-1:0] CS_ONE = 18'h00001;

  dfl_state_t st_reg;
  dfl_state_t st_next;
  logic [dfl_pkg::NUM_FLAGS-1:0] set_vec;
  logic                          wd_over_now;
  logic                          cs_expire;

  // Watchdog past half of its period, only meaningful in flash mode
  always_comb begin
    wd_over_now = flash_mode && (wd_elapsed > (wd_period >> 1)); // [R8]
  end

  // Last low count before the limit; shared by the timer and its check
  function automatic logic cs_at_last(input logic [dfl_pkg::CS_CNT_W-1:0] cnt);
    return cnt == (CS_LIMIT - CS_ONE);
  endfunction

  // Chip select low timeout fires once per low phase, as the count saturates
  always_comb begin
    cs_expire = !chip_select_bar && cs_at_last(st_reg.cs_cnt); // [R5]
  end

  // ========================================================================
  // Set sources; fault flags are set while the fault stands
  always_comb begin
    set_vec                             = dfl_pkg::FLAGS_RST;
    set_vec[dfl_pkg::F_CANL_TO_BAT]     = canl_short_bat;        // [R1]
    set_vec[dfl_pkg::F_CANL_TO_REG]     = canl_short_reg;        // [R1]
    set_vec[dfl_pkg::F_CANL_TO_GND]     = canl_short_gnd;        // [R1]
    set_vec[dfl_pkg::F_CANH_TO_BAT]     = canh_short_bat;        // [R1]
    set_vec[dfl_pkg::F_CANH_TO_REG]     = canh_short_reg;        // [R1]
    set_vec[dfl_pkg::F_CANH_TO_GND]     = canh_short_gnd;        // [R1]
    set_vec[dfl_pkg::F_SW_THREE_SHORT]  = high_side_three_short; // [R3]
    set_vec[dfl_pkg::F_SW_TWO_SHORT]    = high_side_two_short;   // [R3]
    set_vec[dfl_pkg::F_SPI_PARITY]      = spi_parity_fail;       // [R4]
    set_vec[dfl_pkg::F_CS_LONG]         = cs_expire;             // [R5]
    set_vec[dfl_pkg::F_SUP2_UV]         = supply_two_under;      // [R6]
    set_vec[dfl_pkg::F_SUP1_OV]         = supply_one_over;       // [R6]
    set_vec[dfl_pkg::F_IO0_THERMAL]     = io0_switch_hot;        // [R7]
    set_vec[dfl_pkg::F_WD_HALF]         = wd_over_now && !st_reg.wd_over; // [R8]
    set_vec[dfl_pkg::F_WAKE_IO13]       = wake_io13;             // [R9]
    set_vec[dfl_pkg::F_WAKE_IO02]       = wake_io02;             // [R9]
    set_vec[dfl_pkg::F_WAKE_SPI]        = spi_wake_cmd && lp_reg_on_mode; // [R10]
    set_vec[dfl_pkg::F_WAKE_FORCED]     = forced_wake;           // [R11]
    set_vec[dfl_pkg::F_INT_TIMEOUT]     = int_service_expired;   // [R12]
    set_vec[dfl_pkg::F_LP_REG_OFF]      = lp_reg_off_select;     // [R13]
    set_vec[dfl_pkg::F_RST_REQUEST]     = spi_reset_done;        // [R14]
    set_vec[dfl_pkg::F_DEBUG_EXIT]      = debug_mode && debug_entry_pin_low; // [R15]
  end

  // ========================================================================
  // Next state
  // A read clears a flag, but a standing fault re-asserts it in the same
  // cycle, so fault flags need recovery plus a read without extra logic.
  always_comb begin
    st_next         = st_reg;
    st_next.flags   = set_vec | (st_reg.flags & ~flag_read); // [R2] [R16]
    st_next.wd_over = wd_over_now;
    // Saturating low-time counter, restarts at every chip select release
    if (chip_select_bar) begin
      st_next.cs_cnt = '0;
    end else if (st_reg.cs_cnt != CS_LIMIT) begin
      st_next.cs_cnt = st_reg.cs_cnt + CS_ONE; // [R5]
    end
  end

  // State register
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      st_reg.flags   <= dfl_pkg::FLAGS_RST;
      st_reg.cs_cnt  <= '0;
      st_reg.wd_over <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Flags leave straight from the state flops
  assign flags = st_reg.flags;

  // ========================================================================
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  // Low-time counter helper for the chip select check
  logic [dfl_pkg::CS_CNT_W-1:0] chk_cs_low;
  always_ff @(posedge mclk) begin
    if (!rstn || chip_select_bar) begin
      chk_cs_low <= '0;
    end else if (chk_cs_low != CS_LIMIT) begin
      chk_cs_low <= chk_cs_low + CS_ONE;
    end
  end

  property p_can_fault_set;
    canh_short_gnd |=> flags[dfl_pkg::F_CANH_TO_GND];
  endproperty
  a_can_fault_set: assert property (p_can_fault_set) // [R1]
    else $error("bus wire fault not latched");

  property p_fault_read_persist;
    canl_short_bat && flag_read[dfl_pkg::F_CANL_TO_BAT]
      |=> flags[dfl_pkg::F_CANL_TO_BAT];
  endproperty
  a_fault_read_persist: assert property (p_fault_read_persist) // [R2]
    else $error("fault flag cleared while fault stands");

  property p_fault_recover_clear;
    flags[dfl_pkg::F_SW_THREE_SHORT] && !high_side_three_short
      && flag_read[dfl_pkg::F_SW_THREE_SHORT] |=> !flags[dfl_pkg::F_SW_THREE_SHORT];
  endproperty
  a_fault_recover_clear: assert property (p_fault_recover_clear) // [R3]
    else $error("recovered fault flag not cleared by read");

  property p_parity_clear;
    !spi_parity_fail && flag_read[dfl_pkg::F_SPI_PARITY]
      |=> !flags[dfl_pkg::F_SPI_PARITY];
  endproperty
  a_parity_clear: assert property (p_parity_clear) // [R4]
    else $error("parity flag not cleared by read");

  property p_cs_timeout;
    !chip_select_bar && cs_at_last(chk_cs_low)
      && !flag_read[dfl_pkg::F_CS_LONG] |=> flags[dfl_pkg::F_CS_LONG];
  endproperty
  a_cs_timeout: assert property (p_cs_timeout) // [R5]
    else $error("chip select timeout flag missing");

  property p_cs_early;
    $rose(flags[dfl_pkg::F_CS_LONG]) |-> chk_cs_low == CS_LIMIT;
  endproperty
  a_cs_early: assert property (p_cs_early) // [R5]
    else $error("chip select timeout flag set early");

  property p_supply_hold;
    flags[dfl_pkg::F_SUP2_UV] && supply_two_under |=> flags[dfl_pkg::F_SUP2_UV];
  endproperty
  a_supply_hold: assert property (p_supply_hold) // [R6]
    else $error("supply flag dropped during under-voltage");

  property p_thermal_read_clear;
    flags[dfl_pkg::F_IO0_THERMAL] && !io0_switch_hot
      && flag_read[dfl_pkg::F_IO0_THERMAL] |=> !flags[dfl_pkg::F_IO0_THERMAL];
  endproperty
  a_thermal_read_clear: assert property (p_thermal_read_clear) // [R7]
    else $error("thermal flag not cleared after recovery and read");

  property p_wd_needs_flash;
    $rose(flags[dfl_pkg::F_WD_HALF]) |-> $past(flash_mode);
  endproperty
  a_wd_needs_flash: assert property (p_wd_needs_flash) // [R8]
    else $error("watchdog half flag set outside flash mode");

  property p_spi_wake_mode;
    $rose(flags[dfl_pkg::F_WAKE_SPI]) |-> $past(lp_reg_on_mode);
  endproperty
  a_spi_wake_mode: assert property (p_spi_wake_mode) // [R10]
    else $error("SPI wake flag set outside low power mode");

  property p_set_beats_read;
    int_service_expired && flag_read[dfl_pkg::F_INT_TIMEOUT]
      |=> flags[dfl_pkg::F_INT_TIMEOUT] [*1] ##1 1'b1;
  endproperty
  a_set_beats_read: assert property (p_set_beats_read) // [R12] [R16]
    else $error("event lost against a clearing read");

  property p_sticky_event;
    flags[dfl_pkg::F_WAKE_FORCED] && !flag_read[dfl_pkg::F_WAKE_FORCED]
      |=> flags[dfl_pkg::F_WAKE_FORCED];
  endproperty
  a_sticky_event: assert property (p_sticky_event) // [R11]
    else $error("wake flag lost without a read");

  property p_two_short_set;
    high_side_two_short |=> flags[dfl_pkg::F_SW_TWO_SHORT];
  endproperty
  a_two_short_set: assert property (p_two_short_set) // [R3]
    else $error("switch two short not latched");

  property p_supply_one_hold;
    flags[dfl_pkg::F_SUP1_OV] && supply_one_over && flag_read[dfl_pkg::F_SUP1_OV]
      |=> flags[dfl_pkg::F_SUP1_OV];
  endproperty
  a_supply_one_hold: assert property (p_supply_one_hold) // [R6]
    else $error("over-voltage flag cleared while supply stays high");

  // One crossing of the half period gives one flag, however long it stays
  property p_wd_rearm;
    st_reg.wd_over && !flags[dfl_pkg::F_WD_HALF] |=> !flags[dfl_pkg::F_WD_HALF];
  endproperty
  a_wd_rearm: assert property (p_wd_rearm) // [R8]
    else $error("watchdog half flag set twice for one crossing");

  property p_wake_io13_set;
    wake_io13 |=> flags[dfl_pkg::F_WAKE_IO13];
  endproperty
  a_wake_io13_set: assert property (p_wake_io13_set) // [R9]
    else $error("line one or three wake not latched");

  property p_wake_io02_set;
    wake_io02 |=> flags[dfl_pkg::F_WAKE_IO02];
  endproperty
  a_wake_io02_set: assert property (p_wake_io02_set) // [R9]
    else $error("line zero or two wake not latched");

  property p_spi_wake_set;
    spi_wake_cmd && lp_reg_on_mode |=> flags[dfl_pkg::F_WAKE_SPI];
  endproperty
  a_spi_wake_set: assert property (p_spi_wake_set) // [R10]
    else $error("SPI wake from low power not latched");

  property p_forced_read_clear;
    !forced_wake && flag_read[dfl_pkg::F_WAKE_FORCED]
      |=> !flags[dfl_pkg::F_WAKE_FORCED];
  endproperty
  a_forced_read_clear: assert property (p_forced_read_clear) // [R11]
    else $error("forced wake flag not cleared by read");

  property p_lp_off_set;
    lp_reg_off_select |=> flags[dfl_pkg::F_LP_REG_OFF];
  endproperty
  a_lp_off_set: assert property (p_lp_off_set) // [R13]
    else $error("regulator-off selection not latched");

  property p_rst_request_set;
    spi_reset_done |=> flags[dfl_pkg::F_RST_REQUEST];
  endproperty
  a_rst_request_set: assert property (p_rst_request_set) // [R14]
    else $error("reset request cause not latched");

  property p_debug_exit_cause;
    $rose(flags[dfl_pkg::F_DEBUG_EXIT])
      |-> $past(debug_mode) && $past(debug_entry_pin_low);
  endproperty
  a_debug_exit_cause: assert property (p_debug_exit_cause) // [R15]
    else $error("debug exit flag set without a pin drop in debug mode");

  c_can_fault_read: cover property (
    flags[dfl_pkg::F_CANL_TO_GND] ##1 !canl_short_gnd ##[1:4]
    !flags[dfl_pkg::F_CANL_TO_GND]);
  c_cs_timeout: cover property ($rose(flags[dfl_pkg::F_CS_LONG]));
  c_event_vs_read: cover property (forced_wake && flag_read[dfl_pkg::F_WAKE_FORCED]);
  c_wd_half: cover property ($rose(flags[dfl_pkg::F_WD_HALF]));
  c_debug_exit: cover property ($rose(flags[dfl_pkg::F_DEBUG_EXIT]));

endmodule // dfl_flag_bank

// ---- dfl_host_model.sv ----
`timescale 1ns/1ps

// ==========================================================================
// Host side model: gives one-cycle read strobes, like one flag read frame
module dfl_host_model (
  input  wire logic                          mclk,
  output logic      [dfl_pkg::NUM_FLAGS-1:0] flag_read
);
  initial flag_read = 22'h000000;

  // Called at a falling edge; the strobe stands for exactly one rising edge
  task automatic rd(input logic [dfl_pkg::NUM_FLAGS-1:0] mask);
    flag_read = mask;
    @(negedge mclk);
    flag_read = 22'h000000;
  endtask
endmodule // dfl_host_model

// ---- tb_diag_flag_latch_bank.sv ----
`timescale 1ns/1ps

// ==========================================================================
// Flag bank bench; short chip select limit keeps the run brief
module tb_diag_flag_latch_bank;
  localparam int unsigned CS_N = 20;
  logic        mclk = 1'b0;
  logic        rstn;
  logic        chip_select_bar;
  logic        pin_low;
  logic        lp_on;
  logic [21:0] src;
  logic [15:0] wd_el;
  logic [15:0] wd_per;
  logic [21:0] flags;
  logic [21:0] flag_read;
  int          n_errors;
  int          compares;
  int          cycles;

  dfl_host_model host (.mclk(mclk), .flag_read(flag_read));

  dfl_flag_bank #(.CS_LOW_CYCLES(CS_N), .WD_W(16)) dut (
    .mclk(mclk), .rstn(rstn),
    .canl_short_bat(src[0]), .canl_short_reg(src[1]), .canl_short_gnd(src[2]),
    .canh_short_bat(src[3]), .canh_short_reg(src[4]), .canh_short_gnd(src[5]),
    .high_side_three_short(src[6]), .high_side_two_short(src[7]),
    .spi_parity_fail(src[8]), .chip_select_bar(chip_select_bar),
    .supply_two_under(src[10]), .supply_one_over(src[11]),
    .io0_switch_hot(src[12]), .flash_mode(src[13]),
    .wd_elapsed(wd_el), .wd_period(wd_per),
    .wake_io13(src[14]), .wake_io02(src[15]), .spi_wake_cmd(src[16]),
    .lp_reg_on_mode(lp_on), .forced_wake(src[17]), .int_service_expired(src[18]),
    .lp_reg_off_select(src[19]), .spi_reset_done(src[20]), .debug_mode(src[21]),
    .debug_entry_pin_low(pin_low), .flag_read(flag_read), .flags(flags)
  );

  // ========================================================================
  // Clock, timeout and common checks
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Whole run needs well under a thousand cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      end_sim();
    end
  end

  task automatic chk(input string what, input logic [21:0] seen, input logic [21:0] exp);
    compares++;
    if (seen !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      n_errors++;
    end
  endtask

  task automatic end_sim();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // ========================================================================
  // Scenarios
  // Level faults: a read while the fault stands must not clear the flag
  task automatic t_faults();
    int fl[11] = '{0, 1, 2, 3, 4, 5, 6, 7, 10, 11, 12};
    foreach (fl[k]) begin
      src[fl[k]] = 1'b1;
      @(negedge mclk);
      chk("fault set", flags, 22'h000001 << fl[k]);
      host.rd(22'h000001 << fl[k]);
      chk("fault read held", flags[fl[k]], 1'b1);
      src[fl[k]] = 1'b0;
      // Idle cycle keeps the two read strobes apart
      @(negedge mclk);
      chk("fault kept unread", flags[fl[k]], 1'b1);
      host.rd(22'h000001 << fl[k]);
      chk("fault cleared", flags[fl[k]], 1'b0);
    end
    $display("faults test done");
  endtask

  // Pulse events, including a new event landing on the clearing read
  task automatic t_events();
    int ev[7] = '{8, 14, 15, 17, 18, 19, 20};
    foreach (ev[k]) begin
      src[ev[k]] = 1'b1;
      @(negedge mclk);
      src[ev[k]] = 1'b0;
      @(negedge mclk);
      chk("event latched", flags, 22'h000001 << ev[k]);
      src[ev[k]] = 1'b1;
      host.rd(22'h000001 << ev[k]);
      src[ev[k]] = 1'b0;
      chk("event beats read", flags[ev[k]], 1'b1);
      @(negedge mclk);
      host.rd(22'h000001 << ev[k]);
      chk("event read clear", flags[ev[k]], 1'b0);
    end
    $display("events test done");
  endtask

  // Wake command counts only in low-power regulator-on mode
  task automatic t_spi_wake();
    src[16] = 1'b1;
    @(negedge mclk);
    chk("spi wake ignored", flags[16], 1'b0);
    lp_on = 1'b1;
    @(negedge mclk);
    src[16] = 1'b0;
    chk("spi wake set", flags[16], 1'b1);
    host.rd(22'h010000);
    chk("spi wake clear", flags[16], 1'b0);
    lp_on = 1'b0;
    $display("spi wake test done");
  endtask

  // Low pin alone is no exit; only with debug mode active
  task automatic t_debug();
    pin_low = 1'b1;
    @(negedge mclk);
    chk("debug no exit", flags[21], 1'b0);
    src[21] = 1'b1;
    @(negedge mclk);
    src[21] = 1'b0;
    pin_low = 1'b0;
    chk("debug exit set", flags[21], 1'b1);
    host.rd(22'h200000);
    chk("debug exit clear", flags[21], 1'b0);
    $display("debug test done");
  endtask

  // One cycle short of the limit, then exactly the limit
  task automatic t_cs();
    chip_select_bar = 1'b0;
    repeat (CS_N - 1) @(negedge mclk);
    chip_select_bar = 1'b1;
    @(negedge mclk);
    chk("cs short", flags[9], 1'b0);
    chip_select_bar = 1'b0;
    repeat (CS_N) @(negedge mclk);
    chk("cs long", flags[9], 1'b1);
    chip_select_bar = 1'b1;
    host.rd(22'h000200);
    chk("cs clear", flags[9], 1'b0);
    $display("chip select test done");
  endtask

  // Mid-run reset drops latched flags and restarts the chip select timer
  task automatic t_reset();
    src[17] = 1'b1;
    chip_select_bar = 1'b0;
    @(negedge mclk);
    src[17] = 1'b0;
    chk("flag before reset", flags[17], 1'b1);
    rstn = 1'b0;
    @(negedge mclk);
    chk("reset clears", flags, 22'h000000);
    rstn = 1'b1;
    repeat (CS_N - 1) @(negedge mclk);
    chk("cs after reset", flags[9], 1'b0);
    @(negedge mclk);
    chk("cs timed afresh", flags[9], 1'b1);
    chip_select_bar = 1'b1;
    host.rd(22'h000200);
    chk("cs clear after reset", flags[9], 1'b0);
    $display("reset test done");
  endtask

  // Half of 100 is 50: 50 stays quiet, 51 sets, and only in flash mode
  task automatic t_wd();
    wd_per = 16'h0064;
    wd_el = 16'h0033;
    @(negedge mclk);
    chk("wd no flash", flags[13], 1'b0);
    wd_el = 16'h0032;
    src[13] = 1'b1;
    @(negedge mclk);
    chk("wd at half", flags[13], 1'b0);
    wd_el = 16'h0033;
    @(negedge mclk);
    chk("wd past half", flags[13], 1'b1);
    host.rd(22'h002000);
    chk("wd clear", flags[13], 1'b0);
    @(negedge mclk);
    chk("wd no re-set", flags[13], 1'b0);
    src[13] = 1'b0;
    $display("watchdog test done");
  endtask

  // ========================================================================
  // Main sequence
  initial begin
    rstn = 1'b0;
    chip_select_bar = 1'b1;
    pin_low = 1'b0;
    lp_on = 1'b0;
    src = 22'h000000;
    wd_el = 16'h0000;
    wd_per = 16'h0000;
    repeat (12) @(negedge mclk);
    rstn = 1'b1;
    chk("reset flags", flags, 22'h000000);
    t_faults();
    t_events();
    t_spi_wake();
    t_debug();
    t_cs();
    t_reset();
    t_wd();
    end_sim();
  end
endmodule // tb_diag_flag_latch_bank
